// file: rtl/rda_pkg.sv
// constants and types for the day-of-month alarms and crystal oscillator configuration
// Summary of operation
// - each of the two alarms raises its interrupt while its day field equals the current day and its enable is set.
// - on reset the alarm day field holds one and the alarm enable is clear.
// - host writes to an alarm day register sit in a buffer and reach the clock core only on the write-update strobe.
// - the host-readable alarm copy is refreshed from the clock core only on the read-update strobe and otherwise holds.
// - the oscillator frequency status bit is read-only and shows one while the crystal output frequency is valid.
// - a two-bit load field selects 12pF, 22pF, no internal load or 10pF for codes 00, 01, 10 and 11.
// - the clock output enable bit gates the 32kHz output, one enables it, and it resets to one.
// - oscillator mode codes 00 and 10 select low-power operation and code 11 selects low-jitter operation.
// - oscillator mode code 01 runs low-jitter while global low-power is low and low-power while it is high.
// - the upper oscillator bits reset only on supply undervoltage, the lower ones also on global shutdown.
package rda_pkg;

    // serial slave addresses of the two register spaces
    localparam logic [6:0] I2C_ADDR_RTC = 7'h68;
    localparam logic [6:0] I2C_ADDR_PMIC = 7'h3C;

    // register offsets
    localparam logic [7:0] OFF_OSC_32K_CONFIG = 8'h03;
    localparam logic [7:0] OFF_ALARM1_DAY_OF_MONTH = 8'h14;
    localparam logic [7:0] OFF_ALARM2_DAY_OF_MONTH = 8'h1B;

    // alarm day register layout and reset
    localparam int ALM_EN_BIT = 7;
    localparam int ALM_RSVD_BIT = 6;
    localparam logic [5:0] ALM_DAY_RST = 6'h01;
    localparam logic ALM_EN_RST = 1'b0;

    // oscillator configuration layout and reset
    localparam int OSC_OK_BIT = 7;
    localparam int OSC_RSVD_HI_BIT = 6;
    localparam int OSC_LOAD_LSB = 4;
    localparam int OSC_RSVD_LO_BIT = 3;
    localparam int OSC_OUT_EN_BIT = 2;
    localparam int OSC_MODE_LSB = 0;
    localparam logic OSC_RSVD_VAL = 1'b1;
    localparam logic OSC_OUT_EN_RST = 1'b1;

    // oscillator mode and load codes
    localparam logic [1:0] MODE_LOW_POWER = 2'h0;
    localparam logic [1:0] MODE_GLOBAL = 2'h1;
    localparam logic [1:0] MODE_LOW_POWER_ALT = 2'h2;
    localparam logic [1:0] MODE_LOW_JITTER = 2'h3;
    localparam logic [1:0] LOAD_12PF = 2'h0;
    localparam logic [1:0] LOAD_22PF = 2'h1;
    localparam logic [1:0] LOAD_NONE = 2'h2;
    localparam logic [1:0] LOAD_10PF = 2'h3;

    // one alarm day setting
    typedef struct packed {
        logic en;
        logic [5:0] day;
    } rda_alarm_t;

    localparam rda_alarm_t ALM_RST = '{en: ALM_EN_RST, day: ALM_DAY_RST};

    // serial slave states
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ACK_ADDR,
        ST_REG,
        ST_ACK_REG,
        ST_WDATA,
        ST_ACK_W,
        ST_RLOAD,
        ST_RDATA,
        ST_MACK
    } rda_i2c_st_t;

endpackage

// file: rtl/rda_alarm_day.sv
// one double-buffered day-of-month alarm instance
`timescale 1ns/1ps
`default_nettype none
module rda_alarm_day (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic wr_i,
    input wire logic [7:0] wdata_i,
    input wire logic write_update_strobe_i,
    input wire logic read_update_strobe_i,
    input wire logic [5:0] cur_day_i,
    output logic [7:0] rdata_o,
    output logic alarm_instance_interrupt_o
);

    typedef struct packed {
        rda_pkg::rda_alarm_t buf_w;
        rda_pkg::rda_alarm_t core;
        rda_pkg::rda_alarm_t rd;
        logic irq;
    } rda_alm_state_t;

    localparam rda_alm_state_t ALM_STATE_RST = '{
        buf_w: rda_pkg::ALM_RST, core: rda_pkg::ALM_RST, rd: rda_pkg::ALM_RST, irq: 1'b0};

    rda_alm_state_t s_q;
    rda_alm_state_t s_d;

    // buffer, upload, read refresh and day compare
    always_comb begin
        s_d = s_q;
        if (wr_i) begin
            s_d.buf_w = {wdata_i[rda_pkg::ALM_EN_BIT], wdata_i[5:0]}; // bit 6 dropped
        end
        if (write_update_strobe_i) begin
            s_d.core = s_q.buf_w;
        end
        if (read_update_strobe_i) begin
            s_d.rd = s_q.core;
        end
        s_d.irq = s_q.core.en && (s_q.core.day == cur_day_i);
    end

    // all state resets on supply undervoltage
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_q <= ALM_STATE_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign rdata_o = {s_q.rd.en, 1'b0, s_q.rd.day};
    assign alarm_instance_interrupt_o = s_q.irq;

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    a_alarm_match: assert property (
        alarm_instance_interrupt_o == $past(s_q.core.en && s_q.core.day == cur_day_i))
        else $error("alarm interrupt does not follow the day compare");
    a_upload_gate: assert property (
        !write_update_strobe_i |=> s_q.core == $past(s_q.core))
        else $error("clock core alarm changed without write update");
    sequence s_upload;
        write_update_strobe_i ##1 read_update_strobe_i && !write_update_strobe_i;
    endsequence
    a_read_hold: assert property (
        !read_update_strobe_i |=> $stable(rdata_o))
        else $error("alarm read copy changed without read update");
    a_write_readback: assert property (
        s_upload |=> rdata_o == $past({s_q.buf_w.en, 1'b0, s_q.buf_w.day}, 2))
        else $error("buffered alarm not visible after upload and refresh");
    a_rsvd_zero: assert property (
        rdata_o[rda_pkg::ALM_RSVD_BIT] == 1'b0)
        else $error("alarm reserved bit reads one");
    a_reset_value: assert property (disable iff (1'b0)
        $rose(rst_n_i) |-> rdata_o == 8'h01 && !alarm_instance_interrupt_o)
        else $error("alarm register reset value wrong");

endmodule
`default_nettype wire

// file: rtl/rda_top.sv
// serial register slave, two day alarms and 32kHz oscillator configuration
`timescale 1ns/1ps
`default_nettype none
module rda_top #(
    parameter logic [1:0] OTP_LOAD = 2'h0,
    parameter logic [1:0] OTP_MODE = 2'h0
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic glob_shdn_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic write_update_strobe_i,
    input wire logic read_update_strobe_i,
    input wire logic [5:0] cur_day_i,
    input wire logic osc_freq_valid_i,
    input wire logic glob_low_power_i,
    output logic [1:0] alarm_instance_interrupt_o,
    output logic [1:0] crystal_load_select_o,
    output logic clock_output_enable_o,
    output logic osc_low_jitter_o
);

    typedef struct packed {
        logic [1:0] scl_s;
        logic [1:0] sda_s;
        logic scl_p;
        logic sda_p;
        logic [1:0] ok_s;
        logic [1:0] glp_s;
        rda_pkg::rda_i2c_st_t st;
        logic [2:0] bitc;
        logic [7:0] sh;
        logic [7:0] ptr;
        logic sel_rtc;
        logic rw;
        logic sda_oe;
        logic [1:0] load;
        logic out_en;
        logic [1:0] mode;
        logic lj;
    } rda_top_state_t;

    localparam rda_top_state_t TOP_RST = '{
        scl_s: 2'h3, sda_s: 2'h3, scl_p: 1'b1, sda_p: 1'b1, ok_s: 2'h0, glp_s: 2'h0,
        st: rda_pkg::ST_IDLE, bitc: 3'h0, sh: 8'h00, ptr: 8'h00, sel_rtc: 1'b0,
        rw: 1'b0, sda_oe: 1'b0, load: OTP_LOAD, out_en: rda_pkg::OSC_OUT_EN_RST,
        mode: OTP_MODE, lj: 1'b0};

    rda_top_state_t s_q;
    rda_top_state_t s_d;
    logic scl;
    logic sda;
    logic rise;
    logic fall;
    logic start;
    logic stop;
    logic wr;
    logic wr_a1;
    logic wr_a2;
    logic wr_osc;
    logic [7:0] byte_in;
    logic [7:0] rdata;
    logic [7:0] osc_rdata;
    logic [7:0] a1_rdata;
    logic [7:0] a2_rdata;

    // bus line conditions from the synchronised pins
    assign scl = s_q.scl_s[1];
    assign sda = s_q.sda_s[1];
    assign rise = scl && !s_q.scl_p;
    assign fall = !scl && s_q.scl_p;
    assign start = scl && s_q.scl_p && s_q.sda_p && !sda;
    assign stop = scl && s_q.scl_p && !s_q.sda_p && sda;
    assign byte_in = {s_q.sh[6:0], sda};

    // write strobes into the register spaces
    assign wr_a1 = wr && s_q.sel_rtc && (s_q.ptr == rda_pkg::OFF_ALARM1_DAY_OF_MONTH);
    assign wr_a2 = wr && s_q.sel_rtc && (s_q.ptr == rda_pkg::OFF_ALARM2_DAY_OF_MONTH);
    assign wr_osc = wr && !s_q.sel_rtc && (s_q.ptr == rda_pkg::OFF_OSC_32K_CONFIG);

    // oscillator register image; status live, reserved bits fixed
    assign osc_rdata = {s_q.ok_s[1], rda_pkg::OSC_RSVD_VAL, s_q.load,
        rda_pkg::OSC_RSVD_VAL, s_q.out_en, s_q.mode};

    // read mux, unmapped offsets read zero
    always_comb begin
        rdata = 8'h00;
        if (s_q.sel_rtc && s_q.ptr == rda_pkg::OFF_ALARM1_DAY_OF_MONTH) begin
            rdata = a1_rdata;
        end else if (s_q.sel_rtc && s_q.ptr == rda_pkg::OFF_ALARM2_DAY_OF_MONTH) begin
            rdata = a2_rdata;
        end else if (!s_q.sel_rtc && s_q.ptr == rda_pkg::OFF_OSC_32K_CONFIG) begin
            rdata = osc_rdata;
        end
    end

    // serial slave sequencing and oscillator configuration
    always_comb begin
        s_d = s_q;
        wr = 1'b0;
        s_d.scl_s = {s_q.scl_s[0], scl_i};
        s_d.sda_s = {s_q.sda_s[0], sda_i};
        s_d.scl_p = s_q.scl_s[1];
        s_d.sda_p = s_q.sda_s[1];
        s_d.ok_s = {s_q.ok_s[0], osc_freq_valid_i};
        s_d.glp_s = {s_q.glp_s[0], glob_low_power_i};
        if (start) begin
            s_d.st = rda_pkg::ST_ADDR;
            s_d.bitc = 3'h0;
            s_d.sda_oe = 1'b0;
        end else if (stop) begin
            s_d.st = rda_pkg::ST_IDLE;
            s_d.sda_oe = 1'b0;
        end else if (rise) begin
            unique case (s_q.st)
                rda_pkg::ST_ADDR, rda_pkg::ST_REG, rda_pkg::ST_WDATA: begin
                    s_d.sh = byte_in;
                    s_d.bitc = s_q.bitc + 3'h1;
                    if (s_q.bitc == 3'h7) begin
                        if (s_q.st == rda_pkg::ST_ADDR) begin
                            if (byte_in[7:1] == rda_pkg::I2C_ADDR_RTC ||
                                byte_in[7:1] == rda_pkg::I2C_ADDR_PMIC) begin
                                s_d.sel_rtc = (byte_in[7:1] == rda_pkg::I2C_ADDR_RTC);
                                s_d.rw = byte_in[0];
                                s_d.st = rda_pkg::ST_ACK_ADDR;
                            end else begin
                                s_d.st = rda_pkg::ST_IDLE;
                            end
                        end else if (s_q.st == rda_pkg::ST_REG) begin
                            s_d.ptr = byte_in;
                            s_d.st = rda_pkg::ST_ACK_REG;
                        end else begin
                            wr = 1'b1;
                            s_d.st = rda_pkg::ST_ACK_W;
                        end
                    end
                end
                rda_pkg::ST_MACK: begin
                    s_d.st = sda ? rda_pkg::ST_IDLE : rda_pkg::ST_RLOAD; // nack ends the read
                end
                rda_pkg::ST_IDLE, rda_pkg::ST_ACK_ADDR, rda_pkg::ST_ACK_REG,
                rda_pkg::ST_ACK_W, rda_pkg::ST_RLOAD, rda_pkg::ST_RDATA: begin
                end
            endcase
        end else if (fall) begin
            unique case (s_q.st)
                rda_pkg::ST_ACK_ADDR, rda_pkg::ST_ACK_REG, rda_pkg::ST_ACK_W: begin
                    s_d.bitc = 3'h0;
                    if (!s_q.sda_oe) begin
                        s_d.sda_oe = 1'b1; // pull low for acknowledge
                    end else if (s_q.st == rda_pkg::ST_ACK_ADDR && s_q.rw) begin
                        s_d.sh = rdata;
                        s_d.sda_oe = !rdata[7];
                        s_d.st = rda_pkg::ST_RDATA;
                    end else begin
                        s_d.sda_oe = 1'b0;
                        if (s_q.st == rda_pkg::ST_ACK_ADDR) begin
                            s_d.st = rda_pkg::ST_REG;
                        end else begin
                            s_d.st = rda_pkg::ST_WDATA;
                        end
                        if (s_q.st == rda_pkg::ST_ACK_W) begin
                            s_d.ptr = s_q.ptr + 8'h01;
                        end
                    end
                end
                rda_pkg::ST_RLOAD: begin
                    s_d.sh = rdata;
                    s_d.sda_oe = !rdata[7];
                    s_d.bitc = 3'h0;
                    s_d.st = rda_pkg::ST_RDATA;
                end
                rda_pkg::ST_RDATA: begin
                    if (s_q.bitc == 3'h7) begin
                        s_d.sda_oe = 1'b0;
                        s_d.st = rda_pkg::ST_MACK;
                        s_d.ptr = s_q.ptr + 8'h01;
                    end else begin
                        s_d.bitc = s_q.bitc + 3'h1;
                        s_d.sda_oe = !s_q.sh[6];
                        s_d.sh = {s_q.sh[6:0], 1'b0};
                    end
                end
                rda_pkg::ST_IDLE, rda_pkg::ST_ADDR, rda_pkg::ST_REG,
                rda_pkg::ST_WDATA, rda_pkg::ST_MACK: begin
                end
            endcase
        end
        // oscillator fields; status and reserved bits ignore writes
        if (wr_osc) begin
            s_d.load = byte_in[rda_pkg::OSC_LOAD_LSB +: 2];
            s_d.out_en = byte_in[rda_pkg::OSC_OUT_EN_BIT];
            s_d.mode = byte_in[rda_pkg::OSC_MODE_LSB +: 2];
        end
        if (glob_shdn_i) begin
            s_d.out_en = rda_pkg::OSC_OUT_EN_RST;
            s_d.mode = OTP_MODE;
        end
        // effective oscillator mode
        unique case (s_q.mode)
            rda_pkg::MODE_LOW_POWER, rda_pkg::MODE_LOW_POWER_ALT: s_d.lj = 1'b0;
            rda_pkg::MODE_LOW_JITTER: s_d.lj = 1'b1;
            rda_pkg::MODE_GLOBAL: s_d.lj = !s_q.glp_s[1];
        endcase
    end

    // whole block state resets on supply undervoltage
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_q <= TOP_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign sda_o = 1'b0;
    assign sda_oe_o = s_q.sda_oe;
    assign crystal_load_select_o = s_q.load;
    assign clock_output_enable_o = s_q.out_en;
    assign osc_low_jitter_o = s_q.lj;

    rda_alarm_day u_alarm1 (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .wr_i(wr_a1),
        .wdata_i(byte_in),
        .write_update_strobe_i(write_update_strobe_i),
        .read_update_strobe_i(read_update_strobe_i),
        .cur_day_i(cur_day_i),
        .rdata_o(a1_rdata),
        .alarm_instance_interrupt_o(alarm_instance_interrupt_o[0])
    );

    rda_alarm_day u_alarm2 (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .wr_i(wr_a2),
        .wdata_i(byte_in),
        .write_update_strobe_i(write_update_strobe_i),
        .read_update_strobe_i(read_update_strobe_i),
        .cur_day_i(cur_day_i),
        .rdata_o(a2_rdata),
        .alarm_instance_interrupt_o(alarm_instance_interrupt_o[1])
    );

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    // the status synchroniser restarts from zero after reset, so skip its refill
    a_status_read: assert property (
        $past(rst_n_i) && $past(rst_n_i, 2) |->
            osc_rdata[rda_pkg::OSC_OK_BIT] == $past(osc_freq_valid_i, 2))
        else $error("oscillator status bit does not follow valid input");
    a_load_write: assert property (
        wr_osc |=> crystal_load_select_o == $past(byte_in[5:4]))
        else $error("load select not taken from write");
    a_out_en_write: assert property (
        wr_osc && !glob_shdn_i |=> clock_output_enable_o == $past(byte_in[2]))
        else $error("output enable not taken from write");
    a_mode_fixed: assert property (
        s_q.mode != rda_pkg::MODE_GLOBAL |=> osc_low_jitter_o == ($past(s_q.mode) == 2'h3))
        else $error("fixed oscillator mode decoded wrongly");
    a_mode_global: assert property (
        s_q.mode == rda_pkg::MODE_GLOBAL && $past(rst_n_i) && $past(rst_n_i, 2)
            |=> osc_low_jitter_o == !$past(glob_low_power_i, 3))
        else $error("global low-power mode decoded wrongly");
    a_shdn_split: assert property (
        glob_shdn_i |=> ($stable(crystal_load_select_o) || $past(wr_osc))
            && clock_output_enable_o && s_q.mode == OTP_MODE)
        else $error("global shutdown reset wrong oscillator bits");

endmodule
`default_nettype wire

// file: verif/rda_host_model.sv
// host-side serial master model for the register bus
`timescale 1ns/1ps
`default_nettype none
module rda_host_model #(
    parameter int HALF = 8
) (
    input wire logic ref_clk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_low_o
);
    // bus idles released, clock high
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end

    // pins only move on the falling reference edge
    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask

    // start or repeated start; ends with the clock low
    task automatic start_cond();
        sda_low_o = 1'b0;
        tick(HALF);
        scl_o = 1'b1;
        tick(HALF);
        sda_low_o = 1'b1;
        tick(HALF);
        scl_o = 1'b0;
        tick(HALF);
    endtask

    // data rises while the clock is high
    task automatic stop_cond();
        sda_low_o = 1'b1;
        tick(HALF);
        scl_o = 1'b1;
        tick(HALF);
        sda_low_o = 1'b0;
        tick(HALF);
    endtask

    // one bit; data held two cycles past the falling clock to keep hold time
    task automatic bit_io(input logic b, output logic r);
        sda_low_o = ~b;
        tick(HALF);
        scl_o = 1'b1;
        tick(HALF / 2);
        r = sda_i;
        tick(HALF / 2);
        scl_o = 1'b0;
        tick(2);
    endtask

    // eight bits msb first, then the acknowledge slot
    task automatic xfer_byte(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
                             output logic ack_out);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], r);
            rx[i] = r;
        end
        bit_io(ack_in, ack_out);
    endtask

    // single-byte register write; day values chosen by the caller are legal ones
    task automatic write_reg(input logic [6:0] dev, input logic [7:0] off, input logic [7:0] dat,
                             output logic nack);
        logic [7:0] rx;
        logic a0, a1, a2;
        start_cond();
        xfer_byte({dev, 1'b0}, 1'b1, rx, a0);
        xfer_byte(off, 1'b1, rx, a1);
        xfer_byte(dat, 1'b1, rx, a2);
        stop_cond();
        nack = a0 | a1 | a2;
    endtask

    // single-byte register read, closed by a master nack
    task automatic read_reg(input logic [6:0] dev, input logic [7:0] off, output logic [7:0] dat);
        logic [7:0] rx;
        logic a;
        start_cond();
        xfer_byte({dev, 1'b0}, 1'b1, rx, a);
        xfer_byte(off, 1'b1, rx, a);
        start_cond();
        xfer_byte({dev, 1'b1}, 1'b1, rx, a);
        xfer_byte(8'hFF, 1'b1, dat, a);
        stop_cond();
    endtask
endmodule
`default_nettype wire

// file: verif/rda_top_tb.sv
// self-checking bench for the day alarms and oscillator configuration
`timescale 1ns/1ps
`default_nettype none
module rda_top_tb;
    typedef struct packed {
        logic [7:0] wdat;
        logic glp;
        logic ok;
        logic [1:0] load;
        logic en;
        logic lj;
        logic [7:0] rd;
    } rda_row_t;

    // written byte, low-power input, status input, expected pins and readback
    localparam rda_row_t ROWS [5] = '{
        '{8'h84, 1'b1, 1'b0, 2'h0, 1'b1, 1'b0, 8'h4C},
        '{8'h11, 1'b0, 1'b1, 2'h1, 1'b0, 1'b1, 8'hD9},
        '{8'h15, 1'b1, 1'b1, 2'h1, 1'b1, 1'b0, 8'hDD},
        '{8'h66, 1'b0, 1'b0, 2'h2, 1'b1, 1'b0, 8'h6E},
        '{8'h3B, 1'b1, 1'b1, 2'h3, 1'b0, 1'b1, 8'hFB}
    };

    logic ref_clk, rst_n, glob_shdn, scl, sda_line, host_low, sda_oe, wr_upd, rd_upd;
    logic osc_ok, glp, out_en, lj, nack;
    logic [5:0] cur_day;
    logic [1:0] irq, load;
    logic [7:0] rd;
    int errors, checks;

    // open-drain data line with pull-up
    assign sda_line = ~(host_low | sda_oe);

    rda_top #(.OTP_LOAD(2'h2), .OTP_MODE(2'h3)) u_dut (
        .ref_clk_i(ref_clk), .rst_n_i(rst_n), .glob_shdn_i(glob_shdn), .scl_i(scl),
        .sda_i(sda_line), .sda_o(), .sda_oe_o(sda_oe), .write_update_strobe_i(wr_upd),
        .read_update_strobe_i(rd_upd), .cur_day_i(cur_day), .osc_freq_valid_i(osc_ok),
        .glob_low_power_i(glp), .alarm_instance_interrupt_o(irq),
        .crystal_load_select_o(load), .clock_output_enable_o(out_en), .osc_low_jitter_o(lj)
    );

    rda_host_model u_host (
        .ref_clk_i(ref_clk), .sda_i(sda_line), .scl_o(scl), .sda_low_o(host_low)
    );

    // 50 ns clock
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        if (errors == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic wait_cycles(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    // write expecting acknowledge
    task automatic wr(input logic [6:0] dev, input logic [7:0] off, input logic [7:0] dat);
        u_host.write_reg(dev, off, dat, nack);
        check("write nack", {7'h0, nack}, 8'h00);
    endtask

    task automatic rd_chk(input string name, input logic [6:0] dev, input logic [7:0] off,
                          input logic [7:0] exp);
        u_host.read_reg(dev, off, rd);
        check(name, rd, exp);
    endtask

    // one-cycle update strobe, write side or read side
    task automatic pulse_update(input logic rd_side);
        wr_upd = ~rd_side;
        rd_upd = rd_side;
        @(negedge ref_clk);
        wr_upd = 1'b0;
        rd_upd = 1'b0;
    endtask

    initial begin
        errors = 0;
        checks = 0;
        rst_n = 1'b0;
        glob_shdn = 1'b0;
        wr_upd = 1'b0;
        rd_upd = 1'b0;
        cur_day = 6'h05;
        osc_ok = 1'b0;
        glp = 1'b0;
        wait_cycles(5);
        rst_n = 1'b1;
        wait_cycles(4);
        // oscillator configuration rows
        foreach (ROWS[i]) begin
            glp = ROWS[i].glp;
            osc_ok = ROWS[i].ok;
            wr(rda_pkg::I2C_ADDR_PMIC, rda_pkg::OFF_OSC_32K_CONFIG, ROWS[i].wdat);
            wait_cycles(6);
            check("load", {6'h0, load}, {6'h0, ROWS[i].load});
            check("out_en", {7'h0, out_en}, {7'h0, ROWS[i].en});
            check("low_jitter", {7'h0, lj}, {7'h0, ROWS[i].lj});
            rd_chk("osc read", rda_pkg::I2C_ADDR_PMIC, rda_pkg::OFF_OSC_32K_CONFIG, ROWS[i].rd);
        end
        // alarm double buffer: write, upload, refresh
        wr(rda_pkg::I2C_ADDR_RTC, rda_pkg::OFF_ALARM1_DAY_OF_MONTH, 8'hC5);
        wait_cycles(4);
        check("irq before upload", {6'h0, irq}, 8'h00);
        rd_chk("alarm1 stale", rda_pkg::I2C_ADDR_RTC, rda_pkg::OFF_ALARM1_DAY_OF_MONTH, 8'h01);
        pulse_update(1'b0);
        wait_cycles(3);
        check("irq alarm1", {6'h0, irq}, 8'h01);
        rd_chk("alarm1 held", rda_pkg::I2C_ADDR_RTC, rda_pkg::OFF_ALARM1_DAY_OF_MONTH, 8'h01);
        pulse_update(1'b1);
        rd_chk("alarm1 fresh", rda_pkg::I2C_ADDR_RTC, rda_pkg::OFF_ALARM1_DAY_OF_MONTH, 8'h85);
        wr(rda_pkg::I2C_ADDR_RTC, rda_pkg::OFF_ALARM2_DAY_OF_MONTH, 8'h86);
        // write update then read update on back-to-back cycles
        wr_upd = 1'b1;
        @(negedge ref_clk);
        wr_upd = 1'b0;
        rd_upd = 1'b1;
        @(negedge ref_clk);
        rd_upd = 1'b0;
        wait_cycles(2);
        check("irq day differs", {6'h0, irq}, 8'h01);
        rd_chk("alarm2 fresh", rda_pkg::I2C_ADDR_RTC, rda_pkg::OFF_ALARM2_DAY_OF_MONTH, 8'h86);
        cur_day = 6'h06;
        wait_cycles(3);
        check("irq alarm2", {6'h0, irq}, 8'h02);
        wr(rda_pkg::I2C_ADDR_RTC, rda_pkg::OFF_ALARM1_DAY_OF_MONTH, 8'h06);
        pulse_update(1'b0);
        wait_cycles(3);
        check("irq disabled", {6'h0, irq}, 8'h02);
        // global shutdown returns only the lower oscillator bits to their reset values
        wr(rda_pkg::I2C_ADDR_PMIC, rda_pkg::OFF_OSC_32K_CONFIG, 8'h10);
        glob_shdn = 1'b1;
        @(negedge ref_clk);
        glob_shdn = 1'b0;
        wait_cycles(3);
        check("shdn load", {6'h0, load}, 8'h01);
        check("shdn out_en", {7'h0, out_en}, 8'h01);
        check("shdn low_jitter", {7'h0, lj}, 8'h01);
        // supply reset in mid-run
        rst_n = 1'b0;
        wait_cycles(2);
        check("rst load", {6'h0, load}, 8'h02);
        check("rst irq", {6'h0, irq}, 8'h00);
        rst_n = 1'b1;
        wait_cycles(4);
        rd_chk("rst alarm1", rda_pkg::I2C_ADDR_RTC, rda_pkg::OFF_ALARM1_DAY_OF_MONTH, 8'h01);
        rd_chk("rst alarm2", rda_pkg::I2C_ADDR_RTC, rda_pkg::OFF_ALARM2_DAY_OF_MONTH, 8'h01);
        rd_chk("rst osc", rda_pkg::I2C_ADDR_PMIC, rda_pkg::OFF_OSC_32K_CONFIG, 8'hEF);
        // unmapped offset and unknown slave address
        rd_chk("unmapped", rda_pkg::I2C_ADDR_RTC, 8'h20, 8'h00);
        u_host.write_reg(7'h55, 8'h14, 8'h81, nack);
        check("bad address nack", {7'h0, nack}, 8'h01);
        tally_and_finish();
    end
endmodule
`default_nettype wire
